// *** rtl/ldc_dimming_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldc_dimming_top #(
  parameter int unsigned EN_LOW_CYCLES = ldc_pkg::EN_LOW_CYCLES,
  parameter int unsigned PWM_LOW_CYCLES = ldc_pkg::PWM_LOW_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable_pin,
  input wire logic pwm_in,
  input wire logic dimming_freq_set_pin,
  input wire logic [7:0] freq_sel,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [ldc_pkg::CH_COUNT-1:0] led_channel_pins,
  output logic [7:0] dc_level_out,
  output logic shutdown
);
  import ldc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] pwm_brightness_level;
  logic [7:0] dimming_mode_select;
  logic [7:0] dc_current_level;
  logic wr_stb;
  logic [7:0] reg_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic strap_done;
  logic direct_mode;
  logic en_shut;
  logic pwm_shut;
  logic [TMR_W-1:0] en_low_cnt;
  logic [TMR_W-1:0] pwm_low_cnt;
  logic pwm_q;
  logic [TMR_W-1:0] period_cnt;
  logic [TMR_W-1:0] high_cnt;
  logic [TMR_W-1:0] div_den;
  logic [TMR_W:0] div_rem;
  logic [7:0] div_quo;
  logic [3:0] div_step;
  logic [7:0] meas_duty;
  logic [7:0] pre_cnt;
  logic [7:0] slot_cnt;
  logic [7:0] duty_latched;

  // ****************************************
  // register bus
  // ****************************************
  ldc_i2c_slave u_bus (
    .clock(clock),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_stb(wr_stb),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // read mux, unmapped offsets read as zero
  assign rd_data = (reg_addr == OFS_BRIGHTNESS) ? pwm_brightness_level :
                   (reg_addr == OFS_MODE) ? dimming_mode_select :
                   (reg_addr == OFS_DC_LEVEL) ? dc_current_level : 8'h00;
  wire wr_level = wr_stb && (reg_addr == OFS_BRIGHTNESS);
  wire wr_mode = wr_stb && (reg_addr == OFS_MODE);
  wire wr_dc = wr_stb && (reg_addr == OFS_DC_LEVEL);

  // registers return to defaults while the enable-low shutdown (en_shut) holds; an input-low shutdown keeps them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_brightness_level <= RST_BRIGHTNESS;
      dimming_mode_select <= RST_MODE;
      dc_current_level <= RST_DC_LEVEL;
    end else if (en_shut) begin
      pwm_brightness_level <= RST_BRIGHTNESS;
      dimming_mode_select <= RST_MODE;
      dc_current_level <= RST_DC_LEVEL;
    end else begin
      if (wr_level) begin
        pwm_brightness_level <= wr_data;
      end
      if (wr_mode) begin
        dimming_mode_select <= wr_data;
      end
      if (wr_dc) begin
        dc_current_level <= wr_data;
      end
    end
  end

  // ****************************************
  // direct mode strap
  // ****************************************
  // sampled once, on the first edge after reset release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_done <= 1'b0;
      direct_mode <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      direct_mode <= dimming_freq_set_pin & ~scl_in & ~sda_in;
    end
  end

  // ****************************************
  // shutdown timers
  // ****************************************
  wire en_expired = (en_low_cnt >= TMR_W'(EN_LOW_CYCLES));
  wire pwm_expired = (pwm_low_cnt >= TMR_W'(PWM_LOW_CYCLES));

  // strictly longer than the limit: the flag rises one cycle past it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_low_cnt <= '0;
      pwm_low_cnt <= '0;
      en_shut <= 1'b0;
      pwm_shut <= 1'b0;
    end else begin
      en_low_cnt <= enable_pin ? '0 : sat_inc(en_low_cnt);
      en_shut <= !enable_pin && en_expired;
      pwm_low_cnt <= pwm_q ? '0 : sat_inc(pwm_low_cnt);
      pwm_shut <= !pwm_q && pwm_expired;
    end
  end

  // ****************************************
  // input duty measurement
  // ****************************************
  wire pwm_rise = pwm_in & ~pwm_q;
  wire div_busy = (div_step != 4'h0);
  wire [TMR_W:0] rem_shift = {div_rem[TMR_W-1:0], 1'b0};
  wire rem_ge = (rem_shift >= {1'b0, div_den});

  // each rising edge closes a period; duty = high*256/period in 8 steps
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_q <= 1'b0;
      period_cnt <= '0;
      high_cnt <= '0;
      div_den <= '0;
      div_rem <= '0;
      div_quo <= 8'h00;
      div_step <= 4'h0;
    end else begin
      pwm_q <= pwm_in;
      if (pwm_rise) begin
        period_cnt <= TMR_W'(1);
        high_cnt <= TMR_W'(1);
        if (!div_busy && period_cnt != '0) begin
          div_den <= period_cnt;
          div_rem <= {1'b0, high_cnt};
          div_quo <= 8'h00;
          div_step <= DIV_STEPS;
        end
      end else begin
        period_cnt <= sat_inc(period_cnt);
        high_cnt <= pwm_in ? sat_inc(high_cnt) : high_cnt;
      end
      if (div_busy) begin
        div_rem <= rem_ge ? (rem_shift - {1'b0, div_den}) : rem_shift;
        div_quo <= {div_quo[6:0], rem_ge};
        div_step <= div_step - 4'h1;
      end
    end
  end

  // a fully high period overflows the quotient, clamp to full scale
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meas_duty <= DUTY_FULL;
    end else if (div_step == 4'h1) begin
      meas_duty <= (div_rem[TMR_W-1:0] == div_den) ? DUTY_FULL : {div_quo[6:0], rem_ge};
    end
  end

  // ****************************************
  // duty selection
  // ****************************************
  wire mode_level_only = (dimming_mode_select == MODE_LEVEL_ONLY);
  wire mode_ext_only = (dimming_mode_select == MODE_EXT_ONLY);
  wire [7:0] product_duty = mult_msb(meas_duty, pwm_brightness_level);
  // unknown mode codes fall back to product dimming
  wire [7:0] next_duty = mode_level_only ? pwm_brightness_level :
                         mode_ext_only ? meas_duty :
                         product_duty;
  wire uses_level = !mode_ext_only && !direct_mode;

  // ****************************************
  // internal dimming pwm
  // ****************************************
  wire slot_tick = (pre_cnt >= freq_sel);
  wire period_end = slot_tick && (slot_cnt >= PERIOD_LAST);

  // 255 slots per period so a code of 255 stays high all period
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_cnt <= 8'h00;
      slot_cnt <= 8'h00;
      duty_latched <= DUTY_FULL;
    end else begin
      pre_cnt <= slot_tick ? 8'h00 : pre_cnt + 8'h01;
      if (period_end) begin
        slot_cnt <= 8'h00;
        duty_latched <= next_duty;   // new duty only at a period edge
      end else if (slot_tick) begin
        slot_cnt <= slot_cnt + 8'h01;
      end
    end
  end

  wire int_pwm = (slot_cnt < duty_latched);
  wire chop = direct_mode ? pwm_q : int_pwm;
  wire ch_allowed = !shutdown &&
                    (dc_current_level != 8'h00) &&
                    !(uses_level && pwm_brightness_level == 8'h00);

  // ****************************************
  // channel outputs
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      led_channel_pins <= '0;
      dc_level_out <= RST_DC_LEVEL;
      shutdown <= 1'b0;
    end else begin
      shutdown <= en_shut || pwm_shut;
      led_channel_pins <= {CH_COUNT{chop && ch_allowed}};
      dc_level_out <= dc_current_level;
    end
  end
endmodule
`default_nettype wire

// *** pkg/ldc_pkg.sv ***
// ****************************************
// dimming control constants
// ****************************************
`default_nettype none
package ldc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_BRIGHTNESS = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h01;
  localparam logic [7:0] OFS_DC_LEVEL = 8'h07;
  localparam logic [7:0] RST_BRIGHTNESS = 8'hff;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_DC_LEVEL = 8'hff;

  // dimming mode codes held in the mode register
  localparam logic [7:0] MODE_PRODUCT = 8'h01;
  localparam logic [7:0] MODE_EXT_ONLY = 8'h03;
  localparam logic [7:0] MODE_LEVEL_ONLY = 8'h05;

  // bus slave address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2c;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned EN_LOW_TIME_US = 30000;    // 30 ms
  localparam int unsigned PWM_LOW_TIME_US = 30500;   // 30.5 ms
  localparam int unsigned EN_LOW_CYCLES = EN_LOW_TIME_US * CLK_MHZ;
  localparam int unsigned PWM_LOW_CYCLES = PWM_LOW_TIME_US * CLK_MHZ;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int unsigned TMR_W = 22;
  localparam int unsigned CH_COUNT = 6;
  localparam logic [7:0] PERIOD_LAST = 8'hfe;   // 255 slots per period
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [3:0] DIV_STEPS = 4'h8;

  // upper eight bits of an 8x8 product
  function automatic logic [7:0] mult_msb(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] p;
    p = a * b;
    return p[15:8];
  endfunction

  // counter step that sticks at all ones
  function automatic logic [TMR_W-1:0] sat_inc(input logic [TMR_W-1:0] v);
    return (&v) ? v : TMR_W'(v + 1'b1);
  endfunction

endpackage
`default_nettype wire

// *** rtl/ldc_i2c_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldc_i2c_slave (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic wr_stb,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  import ldc_pkg::*;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_ACK_A = 9'h004,
    S_REG = 9'h008,
    S_ACK_R = 9'h010,
    S_WDATA = 9'h020,
    S_ACK_W = 9'h040,
    S_RDATA = 9'h080,
    S_MACK = 9'h100
  } ldc_i2c_st_t;

  ldc_i2c_st_t st;
  logic scl_q;
  logic sda_q;
  logic [2:0] cnt;
  logic byte_done;
  logic rw;
  logic [7:0] sh;

  // ****************************************
  // line events
  // ****************************************
  // start and stop are only legal while the clock line stays high
  wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire addr_hit = (sh[7:1] == DEV_ADDR);
  wire rx_state = (st == S_ADDR) || (st == S_REG) || (st == S_WDATA);

  // ****************************************
  // bit engine: sample on rise, drive on fall
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt <= 3'h0;
      byte_done <= 1'b0;
      rw <= 1'b0;
      sh <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      reg_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      sda_out <= 1'b0;   // open drain: only ever pulls low
      wr_stb <= 1'b0;
      if (start_cond) begin
        st <= S_ADDR;
        cnt <= 3'h0;
        byte_done <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        st <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (rx_state || st == S_RDATA) begin
          if (rx_state) begin
            sh <= {sh[6:0], sda_in};
          end
          cnt <= cnt + 3'h1;
          byte_done <= (cnt == 3'h7);
        end else if (st == S_MACK) begin
          if (sda_in) begin
            st <= S_IDLE;   // master nack ends the read
          end else begin
            reg_addr <= reg_addr + 8'h01;
          end
        end
      end else if (scl_fall) begin
        case (st)
          S_ADDR: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              if (addr_hit) begin
                rw <= sh[0];
                sda_oe <= 1'b1;
                st <= S_ACK_A;
              end else begin
                st <= S_IDLE;
              end
            end
          end
          S_REG: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              reg_addr <= sh;
              sda_oe <= 1'b1;
              st <= S_ACK_R;
            end
          end
          S_WDATA: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              wr_data <= sh;
              wr_stb <= 1'b1;
              sda_oe <= 1'b1;
              st <= S_ACK_W;
            end
          end
          S_ACK_A: begin
            cnt <= 3'h0;
            if (rw) begin
              sh <= rd_data;
              sda_oe <= ~rd_data[7];
              st <= S_RDATA;
            end else begin
              sda_oe <= 1'b0;
              st <= S_REG;
            end
          end
          S_ACK_R: begin
            cnt <= 3'h0;
            sda_oe <= 1'b0;
            st <= S_WDATA;
          end
          S_ACK_W: begin
            cnt <= 3'h0;
            sda_oe <= 1'b0;
            reg_addr <= reg_addr + 8'h01;   // burst writes walk upward
            st <= S_WDATA;
          end
          S_RDATA: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              sda_oe <= 1'b0;
              st <= S_MACK;
            end else begin
              sh <= {sh[6:0], 1'b0};
              sda_oe <= ~sh[6];
            end
          end
          S_MACK: begin
            cnt <= 3'h0;
            sh <= rd_data;
            sda_oe <= ~rd_data[7];
            st <= S_RDATA;
          end
          default: begin
            st <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/ldc_dimming_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker for the dimming control
// ****************************************
module ldc_dimming_asserts #(
  parameter int unsigned EN_LOW_CYCLES = 50,
  parameter int unsigned PWM_LOW_CYCLES = 300
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable_pin,
  input wire logic pwm_in,
  input wire logic dimming_freq_set_pin,
  input wire logic [7:0] freq_sel,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [ldc_pkg::CH_COUNT-1:0] led_channel_pins,
  input wire logic [7:0] dc_level_out,
  input wire logic shutdown
);
  import ldc_pkg::*;
  int unsigned en_cnt;
  int unsigned pwm_cnt;
  logic direct_q;
  logic strap_seen;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // low-time counters, capped so a long idle never wraps them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_cnt <= 0;
      pwm_cnt <= 0;
    end else begin
      en_cnt <= enable_pin ? 0 : ((en_cnt < 99999) ? en_cnt + 1 : en_cnt);
      pwm_cnt <= pwm_in ? 0 : ((pwm_cnt < 99999) ? pwm_cnt + 1 : pwm_cnt);
    end
  end
  // strap pins seen once, at the first edge after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_seen <= 1'b0;
      direct_q <= 1'b0;
    end else if (!strap_seen) begin
      strap_seen <= 1'b1;
      direct_q <= dimming_freq_set_pin & ~scl_in & ~sda_in;
    end
  end
  sequence s_en_long;
    en_cnt == EN_LOW_CYCLES + 2;
  endsequence
  sequence s_pwm_long;
    pwm_cnt == PWM_LOW_CYCLES + 2;
  endsequence
  sequence s_both_high;
    (enable_pin && pwm_in) [*4];
  endsequence
  AST_CH_EQUAL: assert property (led_channel_pins == '0 || &led_channel_pins)
    else $error("channels differ");
  AST_DC_ZERO: assert property ((dc_level_out == 8'h00) [*3] |-> led_channel_pins == '0)
    else $error("channels on at zero level");
  AST_SHUT_OFF: assert property (shutdown [*3] |-> led_channel_pins == '0)
    else $error("channels on in shutdown");
  AST_EN_SHUT: assert property (s_en_long |-> ##[0:8] shutdown)
    else $error("no shutdown after long enable low");
  AST_PWM_SHUT: assert property (s_pwm_long |-> ##[0:8] shutdown)
    else $error("no shutdown after long input low");
  AST_SHUT_CAUSE: assert property ($rose(shutdown) |->
    (en_cnt + 4 > EN_LOW_CYCLES) || (pwm_cnt + 4 > PWM_LOW_CYCLES))
    else $error("shutdown without cause");
  AST_CLEAR: assert property (s_both_high |-> !shutdown)
    else $error("shutdown stuck");
  AST_DIRECT_ON: assert property (direct_q && !shutdown && dc_level_out != 8'h00 &&
    $rose(pwm_in) |-> ##[1:3] &led_channel_pins)
    else $error("direct mode missed rise");
  AST_DIRECT_OFF: assert property (direct_q && $fell(pwm_in) |->
    ##[1:3] led_channel_pins == '0)
    else $error("direct mode missed fall");
  AST_ACK_SCL: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled while bus clock high");
endmodule
bind ldc_dimming_top ldc_dimming_asserts #(
  .EN_LOW_CYCLES(EN_LOW_CYCLES), .PWM_LOW_CYCLES(PWM_LOW_CYCLES)
) u_asserts (.clock(clock), .rst(rst), .enable_pin(enable_pin), .pwm_in(pwm_in),
  .dimming_freq_set_pin(dimming_freq_set_pin), .freq_sel(freq_sel), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .led_channel_pins(led_channel_pins),
  .dc_level_out(dc_level_out), .shutdown(shutdown));
`default_nettype wire

// *** verification/ldc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bus host and external pwm source
// ****************************************
module ldc_host_model (
  input wire logic clock,
  input wire logic sda_oe,
  output logic scl_in,
  output logic sda_in,
  output logic pwm_in
);
  logic sda_drv = 1'b1;
  int hi = 1;
  int lo = 0;
  // open-drain data wire, pulled up when nobody pulls low
  assign sda_in = sda_drv & ~sda_oe;
  initial begin
    scl_in = 1'b1;
  end
  // pwm source; a zero low time holds the input high like a board tie
  always begin
    if (hi == 0 || lo == 0) begin
      pwm_in = (hi != 0);
      @(posedge clock);
      #1;
    end else begin
      pwm_in = 1'b1;
      repeat (hi) @(posedge clock);
      #1;
      pwm_in = 1'b0;
      repeat (lo) @(posedge clock);
      #1;
    end
  end
  // slow bus: four clocks per level, well above the two needed
  task automatic hold();
    repeat (4) @(posedge clock);
    #1;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    hold();
    scl_in = 1'b1;
    hold();
    sda_drv = 1'b0;
    hold();
    scl_in = 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    hold();
    scl_in = 1'b1;
    hold();
    sda_drv = 1'b1;
    hold();
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_drv = b;
    hold();
    scl_in = 1'b1;
    hold();
    r = sda_in;
    scl_in = 1'b0;
    hold();
  endtask
  // eight bits msb first, then the ninth bit; ack is 0 when acknowledged
  task automatic xbyte(input logic [7:0] w, input logic mack, output logic [7:0] r,
    output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(w[i], r[i]);
    end
    xbit(mack, ack);
  endtask
endmodule
`default_nettype wire

// *** verification/led_dimming_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module led_dimming_control_tb;
  import ldc_pkg::*;
  localparam int unsigned EN_N = 50;
  localparam int unsigned PWM_N = 300;
  logic clock = 0;
  logic rst = 1;
  logic enable_pin = 1;
  logic strap = 0;
  logic [7:0] freq_sel = 8'h00;
  logic scl_in, sda_in, sda_out, sda_oe, shutdown, pwm_in, k;
  logic [5:0] led;
  logic [7:0] dc_out, r, b, h, m;
  logic [7:0] rnd = 8'h5a;
  logic [7:0] ofs[4] = '{OFS_BRIGHTNESS, OFS_MODE, OFS_DC_LEVEL, 8'h05};
  logic [7:0] rstv[4] = '{8'hff, 8'h01, 8'hff, 8'h00};
  logic [7:0] modes[3] = '{MODE_LEVEL_ONLY, MODE_EXT_ONLY, MODE_PRODUCT};
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, e, tol;
  always #5 clock = ~clock;
  ldc_host_model host (.clock(clock), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in),
    .pwm_in(pwm_in));
  ldc_dimming_top #(.EN_LOW_CYCLES(EN_N), .PWM_LOW_CYCLES(PWM_N)) uut (.clock(clock),
    .rst(rst), .enable_pin(enable_pin), .pwm_in(pwm_in), .dimming_freq_set_pin(strap),
    .freq_sel(freq_sel), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .led_channel_pins(led), .dc_level_out(dc_out), .shutdown(shutdown));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // duty per mode: brightness, input duty, or top byte of their product
  function automatic logic [7:0] exp_duty(input logic [7:0] mm, hh, bb);
    logic [15:0] p;
    p = hh * bb;
    return (mm == 8'h05) ? bb : ((mm == 8'h03) ? hh : p[15:8]);
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.start();
    host.xbyte({DEV_ADDR, 1'b0}, 1'b1, r, k);
    chk("addr ack", k, 0);
    host.xbyte(a, 1'b1, r, k);
    host.xbyte(d, 1'b1, r, k);
    chk("data ack", k, 0);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host.start();
    host.xbyte({DEV_ADDR, 1'b0}, 1'b1, r, k);
    host.xbyte(a, 1'b1, r, k);
    host.start();
    host.xbyte({DEV_ADDR, 1'b1}, 1'b1, r, k);
    host.xbyte(8'hff, 1'b1, d, k);
    host.stop();
  endtask
  // counts cycles with all channels on
  task automatic duty(input int len, output int c);
    c = 0;
    repeat (len) begin
      @(posedge clock);
      #1;
      c += (led === 6'h3f);
    end
  endtask
  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 70000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    #1 rst = 0;
    repeat (4) @(posedge clock);
    #1;
    chk("dc out reset", dc_out, 8'hff);
    chk("sda out low", sda_out, 0);
    foreach (ofs[i]) begin
      rd(ofs[i], b);
      chk("reset value", b, rstv[i]);
    end
    host.start();
    host.xbyte({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, r, k);
    chk("foreign addr", k, 1);
    host.stop();
    rnd = lfsr(rnd);
    wr(OFS_DC_LEVEL, rnd | 8'h01);
    chk("dc level", dc_out, rnd | 8'h01);
    wr(OFS_MODE, MODE_LEVEL_ONLY);
    wr(OFS_DC_LEVEL, 8'h00);
    duty(255, n);
    chk("dc zero", n, 0);
    wr(OFS_DC_LEVEL, 8'hff);
    // first three rounds use brightness zero, the rest random
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      b = (i < 3) ? 8'h00 : rnd;
      rnd = lfsr(rnd);
      h = {1'b0, rnd[6:0]} + 8'h40;
      m = modes[i % 3];
      host.hi = h;
      host.lo = 255 - h;
      wr(OFS_BRIGHTNESS, b);
      wr(OFS_MODE, m);
      repeat (1020) @(posedge clock);
      duty(255, n);
      e = exp_duty(m, h, b);
      tol = (m == MODE_LEVEL_ONLY || e == 0) ? 0 : 2;
      chk("duty band", n >= e - tol && n <= e + tol, 1);
    end
    wr(OFS_MODE, MODE_LEVEL_ONLY);
    freq_sel = 8'h01;
    repeat (2040) @(posedge clock);
    duty(510, n);
    chk("slow rate duty", n, 2 * b);
    freq_sel = 8'h00;
    enable_pin = 0;
    repeat (EN_N - 10) @(posedge clock);
    #1 chk("short low", shutdown, 0);
    enable_pin = 1;
    repeat (4) @(posedge clock);
    #1 enable_pin = 0;
    repeat (EN_N + 10) @(posedge clock);
    #1 chk("enable shutdown", shutdown, 1);
    enable_pin = 1;
    repeat (6) @(posedge clock);
    #1 chk("enable resume", shutdown, 0);
    host.hi = 0;
    // the running source period ends first, so the low level may start up to 255 cycles late
    repeat (PWM_N + 265) @(posedge clock);
    #1 chk("input shutdown", shutdown, 1);
    host.lo = 0;
    host.hi = 1;
    repeat (8) @(posedge clock);
    #1 chk("input resume", shutdown, 0);
    // strapped restart into direct mode
    rst = 1;
    strap = 1;
    host.scl_in = 0;
    host.sda_drv = 0;
    repeat (3) @(posedge clock);
    #1 rst = 0;
    host.hi = 3;
    host.lo = 4;
    repeat (20) @(posedge clock);
    duty(70, n);
    chk("direct duty", n, 30);
    tally_and_finish();
  end
endmodule
`default_nettype wire
